/* inc/bfs_pkg.sv */
// constants and types for the bus fault status stacking block
package bfs_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SSW = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_SR = 8'h14;
  localparam logic [7:0] REG_DATA = 8'h18;
  localparam logic [7:0] REG_XFER = 8'h1c;
  localparam logic [7:0] REG_RELOAD = 8'h20;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [15:0] SSW_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // control field positions
  localparam int CTRL_EN = 0;

  // fault status word field positions
  localparam int SSW_CLASS = 15;
  localparam int SSW_MOVE = 14;
  localparam int SSW_OSZ_HI = 13;
  localparam int SSW_STEP = 12;
  localparam int SSW_EBRK = 11;
  localparam int SSW_IBRK = 10;
  localparam int SSW_RERUN = 9;
  localparam int SSW_LOCK = 8;
  localparam int SSW_FETCH = 7;
  localparam int SSW_READ = 6;
  localparam int SSW_OSZ_LO = 5;
  localparam int SSW_LEFT_HI = 4;
  localparam int SSW_LEFT_LO = 3;
  localparam int SSW_SPACE_HI = 2;
  localparam int SSW_SPACE_LO = 0;

  // width encodings
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // bytes per operand width
  localparam logic [31:0] BYTES_LONG = 32'h0000_0004;
  localparam logic [31:0] BYTES_WORD = 32'h0000_0002;
  localparam logic [31:0] BYTES_BYTE = 32'h0000_0001;

  // block move transfer budget
  localparam logic [4:0] XFER_TOTAL = 5'h10;

  typedef enum logic [2:0] {
    CL_NONE,
    CL_RELEASED,
    CL_GENERAL,
    CL_BLOCK,
    CL_EXCEPT
  } bfs_class_t;

endpackage : bfs_pkg

/* hdl/bfs_fault_stacker.sv */
// bus fault classification, fault status word building and stacking
`timescale 1ns/10ps

module bfs_fault_stacker
  import bfs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [31:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic faultReq,
  input wire logic faultPrefetch,
  input wire logic faultWrite,
  input wire logic faultLocked,
  input wire logic faultFinalWrite,
  input wire logic faultPeriphMove,
  input wire logic faultBlockXfer,
  input wire logic faultBlockRestart,
  input wire logic faultInException,
  input wire logic faultExcBusErr,
  input wire logic [2:0] faultSpace,
  input wire logic [1:0] faultRemain,
  input wire logic [1:0] faultOrig,
  input wire logic [31:0] faultAddr,
  input wire logic [31:0] faultData,
  input wire logic [31:0] blockNextAddr,
  input wire logic [1:0] blockOpSize,
  input wire logic blockPredec,
  input wire logic [4:0] blockDone,
  input wire logic stepWaiting,
  input wire logic extBrkWaiting,
  input wire logic intBrkWaiting,
  input wire logic [31:0] nextPc,
  input wire logic [15:0] curSr,
  input wire logic instrBoundary,
  input wire logic operandAccess,
  input wire logic exceptionReturn,
  output logic faultTake,
  output logic abortInstr,
  output logic restoreEaRegs,
  output logic haltDouble,
  output logic pendWrite,
  output logic [15:0] stackedSsw,
  output logic [31:0] stackedPc,
  output logic [15:0] stackedSr,
  output logic [31:0] stackedAddr,
  output logic [31:0] stackedData,
  output logic [4:0] stackedXfer,
  output logic rerunValid,
  output logic rerunRead,
  output logic [1:0] rerunSize,
  output logic [2:0] rerunSpace
);

  logic [31:0] ctrl_ff;
  logic halt_ff;
  logic pend_ff;
  logic [15:0] pendSsw_ff;
  logic [15:0] ssw_ff;
  logic [31:0] pc_ff;
  logic [15:0] sr_ff;
  logic [31:0] addr_ff;
  logic [31:0] data_ff;
  logic [4:0] xfer_ff;
  logic take_ff;
  logic restore_ff;
  logic rerun_ff;
  logic rerunRead_ff;
  logic [1:0] rerunSize_ff;
  logic [2:0] rerunSpace_ff;
  logic [7:0] count_ff;
  bfs_class_t last_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  bfs_class_t cls;
  logic faultSeen;
  logic takeWrite;
  logic immediate;
  logic [1:0] leftAdj;
  logic [15:0] common;
  logic [15:0] nxt_ssw;
  logic [31:0] opBytes;
  logic [31:0] nxt_blockAddr;
  logic wbReq;
  logic wbWrite;
  logic [7:0] regOff;
  logic [31:0] rmux;

  // accepted fault events
  assign faultSeen = faultReq & ctrl_ff[CTRL_EN] & ~halt_ff;

  // fault classification
  always_comb begin
    cls = CL_NONE;
    if (faultSeen) begin
      if (faultInException) begin
        if (!faultExcBusErr) begin
          cls = CL_EXCEPT;
        end
      end else if (faultFinalWrite && faultWrite) begin
        cls = CL_RELEASED;
      end else if (faultBlockXfer && !faultPrefetch) begin
        cls = CL_BLOCK;
      end else if (faultBlockRestart && faultPrefetch) begin
        cls = CL_BLOCK;
      end else begin
        cls = CL_GENERAL;
      end
    end
  end

  // dynamic sizing never turns a wider operand into byte
  always_comb begin
    leftAdj = faultRemain;
    if (faultRemain == SZ_BYTE && faultOrig != SZ_BYTE) begin
      leftAdj = SZ_WORD;
    end
  end

  // fields shared by every class, unused bits zero
  always_comb begin
    common = 16'h0000;
    common[SSW_OSZ_HI] = faultOrig[1];
    common[SSW_OSZ_LO] = faultOrig[0];
    common[SSW_LEFT_HI:SSW_LEFT_LO] = leftAdj;
    common[SSW_SPACE_HI:SSW_SPACE_LO] = faultSpace;
  end

  // status word per class
  always_comb begin
    nxt_ssw = common;
    case (cls)
      CL_RELEASED: begin
        nxt_ssw[SSW_RERUN] = 1'b1;
      end
      CL_GENERAL: begin
        nxt_ssw[SSW_EBRK] = extBrkWaiting;
        nxt_ssw[SSW_IBRK] = intBrkWaiting;
        nxt_ssw[SSW_LOCK] = faultLocked;
        nxt_ssw[SSW_FETCH] = faultPrefetch;
        nxt_ssw[SSW_READ] = ~faultWrite;
      end
      CL_BLOCK: begin
        nxt_ssw[SSW_MOVE] = 1'b1;
        nxt_ssw[SSW_STEP] = stepWaiting;
        nxt_ssw[SSW_EBRK] = extBrkWaiting;
        nxt_ssw[SSW_IBRK] = intBrkWaiting;
        nxt_ssw[SSW_RERUN] = faultWrite;
        nxt_ssw[SSW_FETCH] = faultPrefetch;
        nxt_ssw[SSW_READ] = ~faultWrite;
      end
      CL_EXCEPT: begin
        nxt_ssw[SSW_CLASS] = 1'b1;
        nxt_ssw[SSW_STEP] = stepWaiting;
        nxt_ssw[SSW_EBRK] = extBrkWaiting;
        nxt_ssw[SSW_IBRK] = intBrkWaiting;
        nxt_ssw[SSW_READ] = 1'b1;
      end
      default: begin
        nxt_ssw = common;
      end
    endcase
  end

  // next operand address moved by operand size
  always_comb begin
    if (blockOpSize == SZ_LONG) begin
      opBytes = BYTES_LONG;
    end else if (blockOpSize == SZ_WORD) begin
      opBytes = BYTES_WORD;
    end else begin
      opBytes = BYTES_BYTE;
    end
    if (blockPredec) begin
      nxt_blockAddr = blockNextAddr - opBytes;
    end else begin
      nxt_blockAddr = blockNextAddr + opBytes;
    end
  end

  // pending write fault is taken at a boundary or on operand access
  assign takeWrite = pend_ff & (instrBoundary | operandAccess);
  assign immediate = (cls == CL_GENERAL) | (cls == CL_BLOCK);
  assign abortInstr = (pend_ff & operandAccess) | immediate;

  // overlapped write fault waiting for its boundary
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff <= 1'b0;
      pendSsw_ff <= SSW_RST;
    end else if (cls == CL_RELEASED) begin
      pend_ff <= 1'b1;
      pendSsw_ff <= nxt_ssw;
    end else if (takeWrite) begin
      pend_ff <= 1'b0;
    end
  end

  // double fault halt
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halt_ff <= 1'b0;
    end else if (faultSeen && faultInException && faultExcBusErr) begin
      halt_ff <= 1'b1;
    end
  end

  // stacked status word, written by fault or by the handler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ssw_ff <= SSW_RST;
    end else if (takeWrite) begin
      ssw_ff <= pendSsw_ff | {3'h0, stepWaiting, extBrkWaiting, intBrkWaiting, 10'h000};
    end else if (immediate || cls == CL_EXCEPT) begin
      ssw_ff <= nxt_ssw;
    end else if (wbWrite && regOff == REG_SSW) begin
      if (wbSel[0]) begin
        ssw_ff[7:0] <= wbDatW[7:0];
      end
      if (wbSel[1]) begin
        ssw_ff[15:8] <= wbDatW[15:8];
      end
    end
  end

  // recovery context
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_ff <= WORD_RST;
      sr_ff <= SSW_RST;
    end else if (takeWrite || immediate || cls == CL_EXCEPT) begin
      pc_ff <= nextPc;
      sr_ff <= curSr;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_ff <= WORD_RST;
      data_ff <= WORD_RST;
    end else if (cls == CL_BLOCK) begin
      addr_ff <= nxt_blockAddr;
      data_ff <= faultData;
    end else if (cls != CL_NONE) begin
      addr_ff <= faultAddr;
      data_ff <= faultData;
    end else if (wbWrite && regOff == REG_ADDR) begin
      addr_ff <= wbDatW;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_ff <= 5'h00;
    end else if (cls == CL_BLOCK) begin
      xfer_ff <= XFER_TOTAL - (blockDone + 5'h01);
    end
  end

  // take and restore pulses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      take_ff <= 1'b0;
      restore_ff <= 1'b0;
    end else begin
      take_ff <= takeWrite | immediate | (cls == CL_EXCEPT);
      restore_ff <= (cls == CL_GENERAL);
    end
  end

  // fault history for software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= 8'h00;
      last_ff <= CL_NONE;
    end else if (cls != CL_NONE) begin
      count_ff <= count_ff + 8'h01;
      last_ff <= cls;
    end
  end

  // reload of bus attributes on return, only read, width and space used
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rerun_ff <= 1'b0;
      rerunRead_ff <= 1'b0;
      rerunSize_ff <= SZ_LONG;
      rerunSpace_ff <= 3'h0;
    end else begin
      rerun_ff <= exceptionReturn & ssw_ff[SSW_RERUN];
      if (exceptionReturn && ssw_ff[SSW_RERUN]) begin
        rerunRead_ff <= ssw_ff[SSW_READ];
        rerunSize_ff <= ssw_ff[SSW_LEFT_HI:SSW_LEFT_LO];
        rerunSpace_ff <= ssw_ff[SSW_SPACE_HI:SSW_SPACE_LO];
      end
    end
  end

  // wishbone slave, one wait cycle
  assign wbReq = wbCyc & wbStb & ~ack_ff;
  assign wbWrite = wbReq & wbWe;
  assign regOff = wbAdr[7:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (wbWrite && regOff == REG_CTRL && wbSel[0]) begin
      ctrl_ff[CTRL_EN] <= wbDatW[CTRL_EN];
    end
  end

  always_comb begin
    if (regOff == REG_CTRL) begin
      rmux = ctrl_ff;
    end else if (regOff == REG_STATUS) begin
      rmux = {16'h0000, count_ff, 3'h0, halt_ff, pend_ff, last_ff};
    end else if (regOff == REG_SSW) begin
      rmux = {16'h0000, ssw_ff};
    end else if (regOff == REG_ADDR) begin
      rmux = addr_ff;
    end else if (regOff == REG_PC) begin
      rmux = pc_ff;
    end else if (regOff == REG_SR) begin
      rmux = {16'h0000, sr_ff};
    end else if (regOff == REG_DATA) begin
      rmux = data_ff;
    end else if (regOff == REG_XFER) begin
      rmux = {27'h0, xfer_ff};
    end else if (regOff == REG_RELOAD) begin
      rmux = {26'h0, rerunSpace_ff, rerunSize_ff, rerunRead_ff};
    end else begin
      rmux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
      rdat_ff <= WORD_RST;
    end else begin
      ack_ff <= wbReq;
      if (wbReq && !wbWe) begin
        rdat_ff <= rmux;
      end
    end
  end

  assign wbAck = ack_ff;
  assign wbDatR = rdat_ff;
  assign faultTake = take_ff;
  assign restoreEaRegs = restore_ff;
  assign haltDouble = halt_ff;
  assign pendWrite = pend_ff;
  assign stackedSsw = ssw_ff;
  assign stackedPc = pc_ff;
  assign stackedSr = sr_ff;
  assign stackedAddr = addr_ff;
  assign stackedData = data_ff;
  assign stackedXfer = xfer_ff;
  assign rerunValid = rerun_ff;
  assign rerunRead = rerunRead_ff;
  assign rerunSize = rerunSize_ff;
  assign rerunSpace = rerunSpace_ff;

endmodule : bfs_fault_stacker

/* verification/bfs_fault_stacker_checker.sv */
// concurrent checks on the fault stacker ports
`timescale 1ns/10ps
module bfs_fault_stacker_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic faultReq,
  input wire logic faultWrite,
  input wire logic faultInException,
  input wire logic faultExcBusErr,
  input wire logic [2:0] faultSpace,
  input wire logic [4:0] blockDone,
  input wire logic [31:0] nextPc,
  input wire logic instrBoundary,
  input wire logic operandAccess,
  input wire logic exceptionReturn,
  input wire logic faultTake,
  input wire logic abortInstr,
  input wire logic restoreEaRegs,
  input wire logic haltDouble,
  input wire logic pendWrite,
  input wire logic [15:0] stackedSsw,
  input wire logic [31:0] stackedPc,
  input wire logic [4:0] stackedXfer,
  input wire logic rerunValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ack_next_cycle: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("bus request not acked next cycle");
  a_pend_take_pc: assert property (pendWrite && (instrBoundary || operandAccess) |=>
    faultTake && stackedPc == $past(nextPc)) else $error("pending write not taken with pc");
  a_pend_abort: assert property (operandAccess && pendWrite |-> abortInstr)
    else $error("operand access not aborted");
  a_over_word: assert property ($fell(pendWrite) |-> faultTake &&
    stackedSsw[15:14] == 2'h0 && stackedSsw[9:6] == 4'h8) else $error("bad released word");
  a_second_word: assert property (restoreEaRegs |-> faultTake &&
    stackedSsw[15:14] == 2'h0 && !stackedSsw[12] && !stackedSsw[9] &&
    stackedSsw[2:0] == $past(faultSpace) && stackedSsw[6] != $past(faultWrite))
    else $error("bad second type word");
  a_third_word: assert property (faultTake && stackedSsw[14] |-> !stackedSsw[15] &&
    !stackedSsw[8] && stackedSsw[9] == $past(faultWrite) &&
    stackedXfer == 5'h0f - $past(blockDone)) else $error("bad block move stack");
  a_exc_word: assert property (faultTake && stackedSsw[15] |->
    !stackedSsw[14] && stackedSsw[9:6] == 4'h1) else $error("bad exception word");
  a_halt_cause: assert property ($rose(haltDouble) |->
    $past(faultReq && faultInException && faultExcBusErr)) else $error("halt without cause");
  a_halt_keep: assert property (haltDouble |=> haltDouble)
    else $error("halt released");
  a_rerun_cause: assert property (rerunValid |->
    $past(exceptionReturn && stackedSsw[9])) else $error("rerun without cause");

  c_restore: cover property (restoreEaRegs);
  c_rerun: cover property (rerunValid);
  c_halt: cover property (haltDouble);
endmodule : bfs_fault_stacker_checker

bind bfs_fault_stacker bfs_fault_stacker_checker bfs_fault_stacker_checker_inst (.clk,
  .reset_n, .wbCyc, .wbStb, .wbAck, .faultReq, .faultWrite, .faultInException,
  .faultExcBusErr, .faultSpace, .blockDone, .nextPc, .instrBoundary, .operandAccess,
  .exceptionReturn, .faultTake, .abortInstr, .restoreEaRegs, .haltDouble, .pendWrite,
  .stackedSsw, .stackedPc, .stackedXfer, .rerunValid);

/* verification/bfs_fault_stacker_tb.sv */
// self-checking bench for the fault stacker
`timescale 1ns/10ps
module bfs_fault_stacker_tb;
  import bfs_pkg::*;
  logic clk, reset_n, wbCyc, wbStb, wbWe, wbAck, faultReq, faultPrefetch, faultWrite;
  logic faultLocked, faultFinalWrite, faultPeriphMove, faultBlockXfer, faultBlockRestart;
  logic faultInException, faultExcBusErr, blockPredec, stepWaiting, extBrkWaiting;
  logic intBrkWaiting, instrBoundary, operandAccess, exceptionReturn, faultTake, abortInstr;
  logic restoreEaRegs, haltDouble, pendWrite, rerunValid, rerunRead, ab, tk, rs;
  logic [1:0] faultRemain, faultOrig, blockOpSize, rerunSize;
  logic [2:0] faultSpace, rerunSpace;
  logic [3:0] wbSel;
  logic [4:0] blockDone, stackedXfer;
  logic [15:0] curSr, stackedSsw, stackedSr;
  logic [31:0] wbAdr, wbDatW, wbDatR, faultAddr, faultData, blockNextAddr, nextPc;
  logic [31:0] stackedPc, stackedAddr, stackedData, rd;
  int fail_count, check_count;

  bfs_fault_stacker bfs_fault_stacker_inst (.clk, .reset_n, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbSel, .wbDatW, .wbDatR, .wbAck, .faultReq, .faultPrefetch, .faultWrite, .faultLocked,
    .faultFinalWrite, .faultPeriphMove, .faultBlockXfer, .faultBlockRestart,
    .faultInException, .faultExcBusErr, .faultSpace, .faultRemain, .faultOrig, .faultAddr,
    .faultData, .blockNextAddr, .blockOpSize, .blockPredec, .blockDone, .stepWaiting,
    .extBrkWaiting, .intBrkWaiting, .nextPc, .curSr, .instrBoundary, .operandAccess,
    .exceptionReturn, .faultTake, .abortInstr, .restoreEaRegs, .haltDouble, .pendWrite,
    .stackedSsw, .stackedPc, .stackedSr, .stackedAddr, .stackedData, .stackedXfer,
    .rerunValid, .rerunRead, .rerunSize, .rerunSpace);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe} <= {2'h3, we};
    wbAdr <= {24'h0, a};
    wbDatW <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'h1 && n < 20);
    rd = wbDatR;
    {wbCyc, wbStb, wbWe} <= 3'h0;
    if (wbAck !== 1'h1) begin
      fail_count++;
      close_out();
    end
  endtask : wb

  // f: prefetch write locked final periph block restart inexc excbus
  task automatic flt(input logic [8:0] f, input logic [2:0] sp, input logic [1:0] rm,
    input logic [1:0] og);
    @(posedge clk);
    faultReq <= 1'h1;
    {faultPrefetch, faultWrite, faultLocked, faultFinalWrite, faultPeriphMove,
      faultBlockXfer, faultBlockRestart, faultInException, faultExcBusErr} <= f;
    {faultSpace, faultRemain, faultOrig} <= {sp, rm, og};
    @(posedge clk);
    ab = abortInstr;
    faultReq <= 1'h0;
    @(posedge clk);
    tk = faultTake;
    rs = restoreEaRegs;
  endtask : flt

  task automatic t_regs;
    wb(0, REG_CTRL, 0);
    chk(rd, CTRL_RST);
    wb(0, REG_SSW, 0);
    chk(rd, {16'h0, SSW_RST});
    wb(1, REG_PC, 32'hffff_ffff);
    wb(0, REG_PC, 0);
    chk(rd, WORD_RST);
    wb(0, 8'h40, 0);
    chk(rd, 32'h0);
    wb(1, REG_SSW, 32'hffff_ffff);
    wb(0, REG_SSW, 0);
    chk(rd, 32'h0000_ffff);
    wb(1, REG_CTRL, 0);
    flt(9'h100, 3'h5, SZ_WORD, SZ_WORD);
    chk(tk, 0);
    wb(1, REG_CTRL, 1);
    $display("regs done");
  endtask : t_regs

  task automatic t_second;
    flt(9'h100, 3'h5, SZ_WORD, SZ_WORD);
    chk({ab, tk, rs}, 3'h7);
    chk(stackedSsw, 16'h2cd5);
    wb(0, REG_SSW, 0);
    chk(rd, 32'h0000_2cd5);
    flt(9'h010, 3'h1, SZ_BYTE, SZ_LONG);
    chk(rs, 1);
    chk(stackedSsw, 16'h0c51);
    extBrkWaiting <= 1'h0;
    flt(9'h0c0, 3'h1, SZ_BYTE, SZ_BYTE);
    chk(stackedSsw, 16'h0529);
    extBrkWaiting <= 1'h1;
    $display("second done");
  endtask : t_second

  task automatic t_over(input logic ob);
    nextPc <= {16'h0, 15'h2000, ob};
    faultData <= {31'h6f56_df77, ob};
    flt(9'h0a0, 3'h2, SZ_LONG, SZ_LONG);
    chk({ab, tk, pendWrite}, 3'h1);
    {instrBoundary, operandAccess} <= {ob, !ob};
    @(posedge clk);
    ab = abortInstr;
    {instrBoundary, operandAccess} <= 2'h0;
    @(posedge clk);
    chk(ab, !ob);
    chk({faultTake, pendWrite}, 2'h2);
    chk(stackedSsw, 16'h1e02);
    chk(stackedPc, {16'h0, 15'h2000, ob});
    chk(stackedData, {31'h6f56_df77, ob});
    chk(stackedAddr, faultAddr);
    chk(stackedSr, curSr);
    if (!ob) wb(1, REG_SSW, 32'h1c02);
    exceptionReturn <= 1'h1;
    @(posedge clk);
    exceptionReturn <= 1'h0;
    @(posedge clk);
    chk(rerunValid, ob);
    chk({rerunRead, rerunSize, rerunSpace}, {1'h0, SZ_LONG, 3'h2});
    wb(0, REG_RELOAD, 0);
    chk(rd, 32'h0000_0010);
    $display("released write done");
  endtask : t_over

  task automatic t_third;
    blockNextAddr <= 32'h0000_1000;
    blockOpSize <= SZ_WORD;
    blockPredec <= 1'h1;
    blockDone <= 5'h03;
    flt(9'h088, 3'h1, SZ_WORD, SZ_WORD);
    chk({ab, tk, rs}, 3'h6);
    chk(stackedSsw, 16'h7e11);
    chk(stackedAddr, 32'h0000_0ffe);
    chk(stackedXfer, 5'h0c);
    wb(0, REG_XFER, 0);
    chk(rd, 32'h0000_000c);
    flt(9'h104, 3'h6, SZ_WORD, SZ_WORD);
    chk(stackedSsw, 16'h7cd6);
    flt(9'h108, 3'h6, SZ_WORD, SZ_WORD);
    chk(rs, 1);
    $display("block move done");
  endtask : t_third

  task automatic t_exc;
    flt(9'h002, 3'h7, SZ_WORD, SZ_WORD);
    chk({tk, haltDouble}, 2'h2);
    chk(stackedSsw, 16'hbc57);
    flt(9'h003, 3'h7, SZ_WORD, SZ_WORD);
    chk(haltDouble, 1);
    flt(9'h100, 3'h5, SZ_WORD, SZ_WORD);
    chk(tk, 0);
    wb(0, REG_STATUS, 0);
    chk(rd, 32'h0000_0914);
    $display("exception done");
  endtask : t_exc

  initial begin
    {wbCyc, wbStb, wbWe, faultReq, faultPrefetch, faultWrite, faultLocked, faultFinalWrite,
      faultPeriphMove, faultBlockXfer, faultBlockRestart, faultInException, faultExcBusErr,
      faultSpace, faultRemain, faultOrig, instrBoundary, operandAccess, exceptionReturn,
      wbAdr, wbDatW, blockNextAddr, blockOpSize, blockDone, blockPredec, nextPc} = '0;
    {stepWaiting, extBrkWaiting, intBrkWaiting} = 3'h7;
    wbSel = 4'hf;
    faultAddr = 32'h0000_1234;
    faultData = 32'h0;
    curSr = 16'h2700;
    fail_count = 0;
    check_count = 0;
    reset_n = 1'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    t_regs();
    t_second();
    t_over(1'h1);
    t_over(1'h0);
    t_third();
    t_exc();
    close_out();
  end
endmodule : bfs_fault_stacker_tb
